//--- hdl/serial_pkg.sv
// shared constants and types of the async serial transceiver
package serial_pkg;

  // ----------------------------------------------------------------
  // bus and register map
  // ----------------------------------------------------------------
  localparam int ADR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_TXBUF = 8'h08;
  localparam logic [7:0] OFS_RXBUF = 8'h0c;

  // serial_ctrl_one field positions
  localparam int C_TXE = 0;
  localparam int C_RXE = 1;
  localparam int C_TX_STOP_LEN_SEL = 2;
  localparam int C_EVEN = 3;
  localparam int C_PE = 4;
  localparam int C_BRG = 5;
  localparam int C_RXSTOP = 8;
  localparam logic [8:0] CTRL_RESET = 9'h000;

  // serial_status_reg field positions
  localparam int S_TX_BUF_EMPTY_FLAG = 2;
  localparam int S_TX_DONE_FLAG = 3;
  localparam int S_RBFL = 4;
  localparam int S_OERR = 5;
  localparam int S_FRAMING_FLAG = 6;
  localparam int S_PERR = 7;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 200_000_000;
  localparam int BASE_DIV = 13;
  localparam int FAST_DIV = 96;
  localparam logic [2:0] BRG_TIMER = 3'h6;
  localparam logic [2:0] BRG_FAST = 3'h7;
  localparam logic [3:0] RT_A = 4'h7;
  localparam logic [3:0] RT_B = 4'h8;
  localparam logic [3:0] RT_C = 4'h9;
  localparam logic [3:0] RT_LAST = 4'hf;
  localparam logic [3:0] FRAME_BASE = 4'ha;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [ADR_W-1:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_s;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_s;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_RUN = 2'b10
  } tx_st_e;

  typedef enum logic [1:0] {
    RX_HUNT = 2'b01,
    RX_BITS = 2'b10
  } rx_st_e;

endpackage : serial_pkg

//--- hdl/rate_tick.sv
// sub-bit tick generator for the serial transceiver
`timescale 1ns/1ps
module rate_tick
  import serial_pkg::*;
#(
  parameter int BASE = BASE_DIV,
  parameter int FAST = FAST_DIV
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // rate selection
  input wire logic [2:0] rate_select_field,
  input wire logic timer_rate_irq,
  // sixteen ticks per bit
  output logic tick
);

  typedef struct packed {
    logic [11:0] cnt;
    logic tick;
  } st_s;

  st_s st;
  st_s next_st;
  logic [11:0] div;

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (rate_select_field == BRG_FAST) begin
      div = 12'(FAST);
    end else begin
      div = 12'(BASE) << rate_select_field;
    end
    // timer pulses act as the tick directly
    if (rate_select_field == BRG_TIMER) begin
      next_st.cnt = 12'h000;
      next_st.tick = timer_rate_irq;
    end else if (st.cnt >= div - 12'h001) begin
      next_st.cnt = 12'h000;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 12'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;

endmodule : rate_tick

//--- hdl/async_serial_transceiver.sv
// full-duplex async serial transceiver with wishbone registers
`timescale 1ns/1ps
module async_serial_transceiver
  import serial_pkg::*;
#(
  parameter int BASE = BASE_DIV,
  parameter int FAST = FAST_DIV
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // wishbone slave
  input wb_req_s wb_req,
  output wb_rsp_s wb_rsp,
  // serial lines
  input wire logic rxd,
  output logic txd,
  // timer rate source and interrupts
  input wire logic timer_rate_irq,
  output logic tx_irq,
  output logic rx_irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [8:0] ctrl;
    logic tx_buf_empty_flag;
    logic tx_done_flag;
    logic rbfl;
    logic oerr;
    logic framing_flag;
    logic perr;
    logic tx_arm;
    logic rx_arm;
    logic oerr_seen;
    logic [7:0] tx_buf;
    logic tx_full;
    tx_st_e tx_st;
    logic [10:0] tx_sh;
    logic [3:0] tx_left;
    logic [3:0] tx_sub;
    logic txd;
    logic tx_irq;
    rx_st_e rx_st;
    logic [3:0] rx_sub;
    logic [3:0] rx_idx;
    logic [7:0] rx_sh;
    logic s_a;
    logic s_b;
    logic rx_perr;
    logic rx_framing_flag;
    logic [7:0] rx_buf;
    logic rx_irq;
    logic ack;
    logic [31:0] dat;
    logic rxd_m;
    logic rxd_s;
  } st_s;

  st_s st;
  st_s next_st;
  logic tick;
  logic req;
  logic bit_v;
  logic [3:0] sub_n;
  logic [3:0] last_idx;
  logic [3:0] first_stop;
  logic par_exp;
  logic [3:0] tx_len;

  // ----------------------------------------------------------------
  // shared rate generator
  // ----------------------------------------------------------------
  // one tick source feeds both directions
  rate_tick #(
    .BASE(BASE),
    .FAST(FAST)
  ) u_tick (
    .clk(clk),
    .rst(rst),
    .rate_select_field(st.ctrl[C_BRG+:3]),
    .timer_rate_irq(timer_rate_irq),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.tx_irq = 1'b0;
    next_st.rx_irq = 1'b0;
    next_st.ack = 1'b0;
    next_st.dat = 32'h0000_0000;
    bit_v = 1'b0;

    // two-stage line synchroniser
    next_st.rxd_m = rxd;
    next_st.rxd_s = st.rxd_m;

    // frame geometry from the shared configuration
    first_stop = 4'h9 + {3'h0, st.ctrl[C_PE]};
    last_idx = first_stop + {3'h0, st.ctrl[C_RXSTOP]};
    tx_len = FRAME_BASE + {3'h0, st.ctrl[C_PE]}
           + {3'h0, st.ctrl[C_TX_STOP_LEN_SEL]};
    par_exp = (^st.rx_sh) ^ ~st.ctrl[C_EVEN];
    sub_n = st.rx_sub + 4'h1;

    // --------------------------------------------------------------
    // bus access: answered one cycle after the request
    // --------------------------------------------------------------
    req = wb_req.cyc && wb_req.stb && !st.ack;
    if (req) begin
      next_st.ack = 1'b1;
      if (wb_req.we) begin
        unique case (wb_req.adr)
          OFS_CTRL: begin
            if (wb_req.sel[0]) begin
              next_st.ctrl[7:0] = wb_req.dat[7:0];
            end
            if (wb_req.sel[1]) begin
              next_st.ctrl[C_RXSTOP] = wb_req.dat[C_RXSTOP];
            end
          end
          OFS_TXBUF: begin
            // unarmed or disabled writes are dropped silently
            if (wb_req.sel[0] && st.tx_arm
                && st.ctrl[C_TXE]) begin
              next_st.tx_buf = wb_req.dat[7:0];
              next_st.tx_full = 1'b1;
              next_st.tx_buf_empty_flag = 1'b0;
              next_st.tx_arm = 1'b0;
            end
          end
          default: begin
          end
        endcase
      end else begin
        unique case (wb_req.adr)
          OFS_CTRL: begin
            next_st.dat = {23'h00_0000, st.ctrl};
          end
          OFS_STATUS: begin
            next_st.dat[S_TX_BUF_EMPTY_FLAG] = st.tx_buf_empty_flag;
            next_st.dat[S_TX_DONE_FLAG] = st.tx_done_flag;
            next_st.dat[S_RBFL] = st.rbfl;
            next_st.dat[S_OERR] = st.oerr;
            next_st.dat[S_FRAMING_FLAG] = st.framing_flag;
            next_st.dat[S_PERR] = st.perr;
            next_st.tx_arm = 1'b1;
            next_st.rx_arm = 1'b1;
            next_st.oerr_seen = st.oerr;
          end
          OFS_RXBUF: begin
            next_st.dat = {24'h00_0000, st.rx_buf};
            if (st.rx_arm) begin
              next_st.rbfl = 1'b0;
              next_st.perr = 1'b0;
              next_st.framing_flag = 1'b0;
              // only an overrun seen at the status read clears
              if (st.oerr_seen) begin
                next_st.oerr = 1'b0;
              end
              next_st.rx_arm = 1'b0;
              next_st.oerr_seen = 1'b0;
            end
          end
          default: begin
          end
        endcase
      end
    end

    // --------------------------------------------------------------
    // transmitter
    // --------------------------------------------------------------
    unique case (st.tx_st)
      TX_IDLE: begin
        next_st.txd = 1'b1;
        if (tick && st.tx_full && st.ctrl[C_TXE]) begin
          next_st.tx_st = TX_RUN;
          next_st.txd = 1'b0;
          // stop, parity or stop, data; start already out
          next_st.tx_sh = {2'b11,
            st.ctrl[C_PE] ? ((^st.tx_buf) ^ ~st.ctrl[C_EVEN])
                          : 1'b1,
            st.tx_buf};
          next_st.tx_left = tx_len - 4'h1;
          next_st.tx_sub = 4'h0;
          // a byte written in this very cycle stays queued
          next_st.tx_full = st.tx_arm && !next_st.tx_arm;
          next_st.tx_buf_empty_flag = 1'b1;
          next_st.tx_irq = 1'b1;
          next_st.tx_done_flag = 1'b0;
        end
      end
      TX_RUN: begin
        if (tick) begin
          next_st.tx_sub = st.tx_sub + 4'h1;
          if (st.tx_sub == RT_LAST) begin
            if (st.tx_left == 4'h0) begin
              next_st.tx_st = TX_IDLE;
              next_st.txd = 1'b1;
              if (!st.tx_full) begin
                next_st.tx_done_flag = 1'b1;
              end
            end else begin
              next_st.txd = st.tx_sh[0];
              next_st.tx_sh = {1'b1, st.tx_sh[10:1]};
              next_st.tx_left = st.tx_left - 4'h1;
            end
          end
        end
      end
      default: begin
        next_st.tx_st = TX_IDLE;
        next_st.txd = 1'b1;
      end
    endcase

    // --------------------------------------------------------------
    // receiver
    // --------------------------------------------------------------
    unique case (st.rx_st)
      RX_HUNT: begin
        // enable and overrun only gate a new frame
        if (tick && !st.rxd_s && st.ctrl[C_RXE]
            && !st.oerr) begin
          next_st.rx_st = RX_BITS;
          next_st.rx_sub = 4'h0;
          next_st.rx_idx = 4'h0;
          next_st.rx_perr = 1'b0;
          next_st.rx_framing_flag = 1'b0;
        end
      end
      RX_BITS: begin
        if (tick) begin
          next_st.rx_sub = sub_n;
          if (sub_n == 4'h0) begin
            next_st.rx_idx = st.rx_idx + 4'h1;
          end
          if (sub_n == RT_A) begin
            next_st.s_a = st.rxd_s;
          end
          if (sub_n == RT_B) begin
            next_st.s_b = st.rxd_s;
          end
          if (sub_n == RT_C) begin
            bit_v = (st.s_a & st.s_b) | (st.s_a & st.rxd_s)
                  | (st.s_b & st.rxd_s);
            if (st.rx_idx == 4'h0) begin
              // a start that votes high was only a glitch
              if (bit_v) begin
                next_st.rx_st = RX_HUNT;
              end
            end else if (st.rx_idx <= 4'h8) begin
              next_st.rx_sh = {bit_v, st.rx_sh[7:1]};
            end else if (st.rx_idx < first_stop) begin
              if (bit_v != par_exp) begin
                next_st.rx_perr = 1'b1;
              end
            end else begin
              if (!bit_v) begin
                next_st.rx_framing_flag = 1'b1;
              end
            end
            if (st.rx_idx == last_idx) begin
              // frame ends at mid stop bit, ready for next edge
              next_st.rx_st = RX_HUNT;
              next_st.rx_irq = 1'b1;
              if (st.rbfl) begin
                next_st.oerr = 1'b1;
              end else begin
                next_st.rx_buf = st.rx_sh;
                next_st.rbfl = 1'b1;
                next_st.perr = st.rx_perr;
                next_st.framing_flag = st.rx_framing_flag | !bit_v;
              end
            end
          end
        end
      end
      default: begin
        next_st.rx_st = RX_HUNT;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
      st.ctrl <= CTRL_RESET;
      st.tx_buf_empty_flag <= 1'b1;
      st.tx_done_flag <= 1'b1;
      st.tx_st <= TX_IDLE;
      st.rx_st <= RX_HUNT;
      st.txd <= 1'b1;
      st.rxd_m <= 1'b1;
      st.rxd_s <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign wb_rsp.ack = st.ack;
  assign wb_rsp.dat = st.dat;
  assign txd = st.txd;
  assign tx_irq = st.tx_irq;
  assign rx_irq = st.rx_irq;

endmodule : async_serial_transceiver

//--- test/serial_link_monitor.sv
// bus and line checker for the async serial transceiver
`timescale 1ns/1ps
module serial_link_monitor
  import serial_pkg::*;
#(
  parameter int BASE = BASE_DIV,
  parameter int FAST = FAST_DIV
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus
  input wb_req_s wb_req,
  input wb_rsp_s wb_rsp,
  // lines and events
  input wire logic rxd,
  input wire logic txd,
  input wire logic timer_rate_irq,
  input wire logic tx_irq,
  input wire logic rx_irq
);
  // ----
  // helper: cycles since the receive line was last low
  // ----
  logic [11:0] low_age;
  always_ff @(posedge clk) begin
    if (rst || !rxd) low_age <= rst ? 12'hfff : 12'h000;
    else if (low_age != 12'hfff) low_age <= low_age + 12'h001;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ----
  // assertions
  // ----
  a_ack_one_late: assert property (wb_req.cyc && wb_req.stb && !wb_rsp.ack
    |=> wb_rsp.ack) else $error("ack late");
  a_ack_single: assert property (wb_rsp.ack |=> !wb_rsp.ack)
    else $error("ack too long");
  a_idle_dat_zero: assert property (!wb_rsp.ack |-> wb_rsp.dat == 32'h0)
    else $error("data without ack");
  a_txbuf_reads_zero: assert property (wb_rsp.ack && !$past(wb_req.we) &&
    $past(wb_req.adr) == OFS_TXBUF |-> wb_rsp.dat == 32'h0)
    else $error("tx buffer readable");
  a_start_low: assert property (tx_irq |-> !txd)
    else $error("no start bit with tx irq");
  a_start_hold: assert property (tx_irq |=> !txd [*7])
    else $error("start bit short");
  a_irq_pulses: assert property (tx_irq || rx_irq |=> !tx_irq && !rx_irq)
    else $error("irq not a pulse");
  a_rx_needs_frame: assert property (rx_irq |-> low_age < 12'd1200)
    else $error("rx irq without frame");
  a_reset_quiet: assert property (@(posedge clk) disable iff (1'b0)
    rst |=> txd && !wb_rsp.ack && !tx_irq)
    else $error("reset outputs wrong");
  c_tx: cover property (tx_irq);
  c_rx: cover property (rx_irq);
  c_read: cover property (wb_rsp.ack && !wb_req.we);
endmodule : serial_link_monitor
bind async_serial_transceiver serial_link_monitor #(.BASE(BASE), .FAST(FAST))
  serial_link_monitor_i (.clk(clk), .rst(rst), .wb_req(wb_req),
  .wb_rsp(wb_rsp), .rxd(rxd), .txd(txd), .timer_rate_irq(timer_rate_irq),
  .tx_irq(tx_irq), .rx_irq(rx_irq));

//--- test/serial_peer.sv
// remote serial device model
`timescale 1ns/1ps
module serial_peer (
  // clock and lines
  input wire logic clk,
  input wire logic txd,
  output logic rxd,
  // frame format; st2 only sets how many txd slots are sampled
  input wire logic [7:0] bclk,
  input wire logic pe,
  input wire logic even,
  input wire logic st2,
  // decoded bytes
  output logic [7:0] got,
  output logic got_bad,
  output logic got_v
);
  logic [11:0] sh;
  initial begin
    rxd = 1'b1;
    got_v = 1'b0;
  end
  // one frame, optionally with bad parity or a low stop bit
  task automatic send(input logic [7:0] d, input logic bp, input logic bs);
    logic [10:0] f;
    f = pe ? {~bs, ^d ^ ~even ^ bp, d, 1'b0}
           : {1'b1, ~bs, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd <= f[i];
      repeat (bclk) @(posedge clk);
    end
    rxd <= 1'b1;
  endtask : send
  // mid-bit sampling; unsampled stop slots stay high
  always begin
    @(negedge txd);
    repeat (bclk / 2) @(posedge clk);
    sh = '1;
    for (int i = 0; i < 10 + pe + st2; i++) begin
      if (i > 0) repeat (bclk) @(posedge clk);
      sh[i] = txd;
    end
    got <= sh[8:1];
    got_bad <= sh[0] | (pe & (sh[9] ^ ^sh[8:1] ^ ~even)) |
      ~&(sh[11:9] | {2'b00, pe});
    got_v <= 1'b1;
    @(posedge clk);
    got_v <= 1'b0;
  end
endmodule : serial_peer

//--- test/async_serial_transceiver_tb_top.sv
// self-checking bench for the async serial transceiver
`timescale 1ns/1ps
module async_serial_transceiver_tb_top
  import serial_pkg::*;
;
  logic clk, rst, rxd, txd, tmr, tx_irq, rx_irq, got_v, got_bad;
  logic pe, even, st2;
  logic [1:0] tc;
  logic [7:0] got, bclk, a, b, c;
  wb_req_s wb_req;
  wb_rsp_s wb_rsp;
  logic [63:0] bus_q[$];
  logic [63:0] line_q[$];
  int fails, checks, n;
  int seed = 32'h51fe_e12e;
  async_serial_transceiver #(.BASE(2), .FAST(3)) async_serial_transceiver_i (
    .clk(clk), .rst(rst), .wb_req(wb_req), .wb_rsp(wb_rsp), .rxd(rxd),
    .txd(txd), .timer_rate_irq(tmr), .tx_irq(tx_irq), .rx_irq(rx_irq));
  serial_peer serial_peer_i (.clk(clk), .txd(txd), .rxd(rxd), .bclk(bclk),
    .pe(pe), .even(even), .st2(st2), .got(got), .got_bad(got_bad),
    .got_v(got_v));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // timer pulse every 4 clocks, so 64 clocks a bit
  always @(posedge clk) begin
    tc <= rst ? 2'h0 : tc + 2'h1;
    tmr <= tc == 2'h3;
  end
  // ----
  // bus tasks and comparison
  // ----
  task automatic bus(input logic w, input logic [7:0] ad,
    input logic [31:0] d);
    @(posedge clk);
    wb_req <= '{1'b1, 1'b1, w, ad, 4'hf, d};
    // held until ack; only the watchdog ends a hung wait
    do begin
      @(posedge clk);
    end while (wb_rsp.ack !== 1'b1);
    wb_req <= '0;
  endtask : bus
  task automatic rd(input logic [7:0] ad, input logic [31:0] m,
    input logic [31:0] e);
    bus_q.push_back({m, e});
    bus(1'b0, ad, 32'h0);
  endtask : rd
  task automatic cmp(input logic [31:0] g, input logic [63:0] e);
    checks++;
    if ((g & e[63:32]) !== e[31:0]) begin
      fails++;
      $display("wrong value at %0t: %h, want %h", $time, g, e[31:0]);
    end
  endtask : cmp
  task automatic tally_and_finish;
    if (bus_q.size() + line_q.size() > 0) fails++;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish
  // results are matched against the oldest note
  always @(posedge clk) begin
    if (wb_rsp.ack === 1'b1 && wb_req.we === 1'b0)
      cmp(wb_rsp.dat, bus_q.size() ? bus_q.pop_front() : '1);
    if (got_v === 1'b1)
      cmp({23'h0, got_bad, got}, line_q.size() ? line_q.pop_front() : '1);
  end
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    tally_and_finish();
  end
  // ----
  // scenarios
  // ----
  initial begin
    rst = 1'b1;
    wb_req = '0;
    {pe, even, st2, bclk} = {3'b000, 8'd32};
    fails = 0;
    checks = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(OFS_CTRL, 32'h1ff, 32'h0);
    rd(8'h10, '1, 32'h0);
    rd(OFS_TXBUF, '1, 32'h0);
    bus(1'b1, OFS_CTRL, 32'h1);
    bus(1'b1, OFS_TXBUF, 32'h5a);
    for (n = 0; n < 200; n++) begin
      @(posedge clk);
      cmp({31'h0, txd}, {32'h1, 32'h1});
    end
    rd(OFS_STATUS, 32'hff, 32'h0c);
    for (int k = 0; k < 5; k++) begin
      // codes 0, 1, fast and timer; two receive stops once
      bclk = k == 4 ? 8'd64 : k == 2 ? 8'd48 : 8'(32 << (k & 1));
      {pe, st2} = k[1:0];
      even = k[0];
      bus(1'b1, OFS_CTRL, {23'h0, k == 1, k == 4 ? BRG_TIMER : k == 2 ?
        BRG_FAST : 3'(k & 1), pe, even, st2, 2'b11});
      a = 8'($random(seed));
      b = 8'($random(seed));
      c = 8'($random(seed));
      line_q.push_back({32'h1ff, 24'h0, a});
      line_q.push_back({32'h1ff, 24'h0, b});
      rd(OFS_STATUS, 32'h04, 32'h04);
      bus(1'b1, OFS_TXBUF, {24'h0, a});
      for (n = 0; n < 99 && tx_irq !== 1'b1; n++) @(posedge clk);
      cmp({31'h0, tx_irq}, {32'h1, 32'h1});
      rd(OFS_STATUS, 32'h04, 32'h04);
      bus(1'b1, OFS_TXBUF, {24'h0, b});
      serial_peer_i.send(c, 1'b0, 1'b0);
      rd(OFS_STATUS, 32'h10, 32'h10);
      rd(OFS_RXBUF, 32'hff, {24'h0, c});
      repeat (14 * bclk) @(posedge clk);
      rd(OFS_STATUS, 32'h0c, 32'h0c);
    end
    // overrun, then parity and framing errors, receive only
    {pe, even, st2, bclk} = {3'b110, 8'd32};
    bus(1'b1, OFS_CTRL, 32'h1a);
    a = 8'($random(seed));
    serial_peer_i.send(a, 1'b0, 1'b0);
    rd(OFS_STATUS, 32'h30, 32'h10);
    serial_peer_i.send(~a, 1'b0, 1'b0);
    rd(OFS_RXBUF, 32'hff, {24'h0, a});
    rd(OFS_STATUS, 32'hf0, 32'h20);
    serial_peer_i.send(~a, 1'b0, 1'b0);
    rd(OFS_STATUS, 32'h30, 32'h20);
    rd(OFS_RXBUF, 32'hff, {24'h0, a});
    rd(OFS_STATUS, 32'hf0, 32'h0);
    serial_peer_i.send(a, 1'b1, 1'b0);
    rd(OFS_STATUS, 32'hd0, 32'h90);
    rd(OFS_RXBUF, 32'hff, {24'h0, a});
    serial_peer_i.send(a, 1'b0, 1'b1);
    rd(OFS_STATUS, 32'hd0, 32'h50);
    rd(OFS_RXBUF, 32'hff, {24'h0, a});
    rd(OFS_STATUS, 32'hf0, 32'h0);
    repeat (4) @(posedge clk);
    tally_and_finish();
  end
endmodule : async_serial_transceiver_tb_top
